// [rtl/conv_clock_divider_map.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef CONV_CLOCK_DIVIDER_MAP_VH
`define CONV_CLOCK_DIVIDER_MAP_VH
// Register byte addresses
`define CONV_CLOCK_DIVIDER_CTRL1_ADDR 12'h000
`define CONV_CLOCK_DIVIDER_CTRL2_ADDR 12'h004
`define CONV_CLOCK_DIVIDER_CTRL3_ADDR 12'h008
`define CONV_CLOCK_DIVIDER_INSEL_ADDR 12'h00C
`define CONV_CLOCK_DIVIDER_PINCFG_ADDR 12'h010
`define CONV_CLOCK_DIVIDER_SCAN_ADDR 12'h014
`define CONV_CLOCK_DIVIDER_STAT_ADDR 12'h018
// Control one fields
`define CONV_CLOCK_DIVIDER_C1_ON 15
`define CONV_CLOCK_DIVIDER_C1_TRIG_HI 7
`define CONV_CLOCK_DIVIDER_C1_TRIG_LO 5
`define CONV_CLOCK_DIVIDER_C1_AUTO 2
`define CONV_CLOCK_DIVIDER_C1_SAMPLE_BIT 1
`define CONV_CLOCK_DIVIDER_C1_DONE 0
`define CONV_CLOCK_DIVIDER_C1_WMASK 16'hA0E7
// Control two fields
`define CONV_CLOCK_DIVIDER_C2_REF_HI 15
`define CONV_CLOCK_DIVIDER_C2_REF_LO 13
`define CONV_CLOCK_DIVIDER_C2_SCAN 10
`define CONV_CLOCK_DIVIDER_C2_BUFFER_FILL_STATUS 7
`define CONV_CLOCK_DIVIDER_C2_SPI_HI 5
`define CONV_CLOCK_DIVIDER_C2_SPI_LO 2
`define CONV_CLOCK_DIVIDER_C2_BUFFER_SPLIT_MODE 1
`define CONV_CLOCK_DIVIDER_C2_ALTERNATE_MUX_MODE 0
`define CONV_CLOCK_DIVIDER_C2_WMASK 16'hE43F
// Control three fields
`define CONV_CLOCK_DIVIDER_C3_SRC 15
`define CONV_CLOCK_DIVIDER_C3_AUTO_SAMPLE_TIME_HI 12
`define CONV_CLOCK_DIVIDER_C3_AUTO_SAMPLE_TIME_LO 8
`define CONV_CLOCK_DIVIDER_C3_WMASK 16'h9FFF
// Input select writable bits
`define CONV_CLOCK_DIVIDER_INSEL_WMASK 16'h9F9F
// Trigger code for auto-convert
`define CONV_CLOCK_DIVIDER_TRIG_AUTO 3'h7
// Reset values
`define CONV_CLOCK_DIVIDER_RESET_VAL 16'h0000
// Conversion length in conversion clock periods; RC clock as a fixed pclk divide
`define CONV_CLOCK_DIVIDER_CONV_TAD 12
`define CONV_CLOCK_DIVIDER_RC_DIV 8
`endif

// [rtl/conv_clock_divider_ctrl.v]
// Converter sequencing and configuration control with APB registers
// Function
// - Reference code picks converter reference pair
// - Scan enable replaces mux A positive input
// - Fill status shows half being written
// - Interrupt every sequences field plus one
// - Buffer mode splits into two halves
// - Alternate mode: A first, then B/A
// - Clock source bit picks RC or divider
// - Sample time counts conversion clock periods
// - Divider period is field plus one cycles
// - Negative select picks channel 1 or ref
// - Positive select codes map to channels
// - Mux A decodes same codes as B
// - Pin bits select digital or analog mode
// - Upper pin bits disable internal channels
// - Scan mask bits include matching channels
// - Auto trigger ends sampling after sample time
// - Auto-start resamples after each conversion
`timescale 1ns/1ps
`default_nettype none
`include "conv_clock_divider_map.vh"
module conv_clock_divider_ctrl #(
    parameter CONV_TAD = `CONV_CLOCK_DIVIDER_CONV_TAD,
    parameter RC_DIV = `CONV_CLOCK_DIVIDER_RC_DIV
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Converter core
    output reg [3:0] ref_select,
    output reg [4:0] pos_channel,
    output reg neg_is_ch1,
    output reg [15:0] channel_enable,
    output reg sample_hold,
    output reg convert_start,
    output reg [3:0] result_addr,
    output reg result_write,
    output reg conv_irq,
    input wire [9:0] core_result,
    // Pin configuration
    output reg [12:0] pin_digital_mode
);
    // Mode states, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE_BIT = 3'b010;
    localparam ST_CONV = 3'b100;

    // Software registers
    reg [15:0] ctrl1;
    reg [15:0] ctrl2;
    reg [15:0] ctrl3;
    reg [15:0] insel;
    reg [15:0] pincfg;
    reg [15:0] scanmask;
    // Sequencer state
    reg [2:0] state;
    reg [7:0] div_cnt;
    reg tad_tick;
    reg [4:0] tad_cnt;
    reg [3:0] seq_cnt;
    reg use_b;
    reg [3:0] scan_idx;
    reg half;
    reg [2:0] fill_ptr;
    reg sample_bit_clr;
    reg sample_bit_set;
    reg done_set;
    reg [9:0] last_result;

    wire on = ctrl1[`CONV_CLOCK_DIVIDER_C1_ON];
    wire wr = psel & penable & pwrite;
    wire rd_sel = psel & ~penable & ~pwrite;
    wire [3:0] spi = ctrl2[`CONV_CLOCK_DIVIDER_C2_SPI_HI:`CONV_CLOCK_DIVIDER_C2_SPI_LO];
    wire [4:0] auto_sample_time = ctrl3[`CONV_CLOCK_DIVIDER_C3_AUTO_SAMPLE_TIME_HI:`CONV_CLOCK_DIVIDER_C3_AUTO_SAMPLE_TIME_LO];
    wire [2:0] trig = ctrl1[`CONV_CLOCK_DIVIDER_C1_TRIG_HI:`CONV_CLOCK_DIVIDER_C1_TRIG_LO];
    // RC clock modelled as a fixed divide, else the system clock divider
    wire [7:0] div_limit = ctrl3[`CONV_CLOCK_DIVIDER_C3_SRC] ? RC_DIV[7:0] - 8'h01 : ctrl3[7:0];

    // Always ready, no wait states
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Positive select code to implemented-channel flag
    function code_ok;
        input [4:0] c;
        begin
            code_ok = (c <= 5'h0F) | (c == 5'h1F);
        end
    endfunction

    // Next enabled channel above a given index in the scan mask
    function [3:0] next_scan;
        input [15:0] m;
        input [3:0] from;
        input first;
        integer i;
        reg found;
        begin
            next_scan = 4'h0;
            found = 1'b0;
            // Downward walk: every bit above the start is seen before any below it
            for (i = 15; i >= 0; i = i - 1) begin
                if (m[i] && (first || i > from)) begin
                    next_scan = i[3:0];
                    found = 1'b1;
                end else if (m[i] && !found) begin
                    // Wrap to lowest when nothing is above
                    next_scan = i[3:0];
                end
            end
        end
    endfunction

    // Register writes; hardware set of sample bit beats software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1 <= `CONV_CLOCK_DIVIDER_RESET_VAL;
            ctrl2 <= `CONV_CLOCK_DIVIDER_RESET_VAL;
            ctrl3 <= `CONV_CLOCK_DIVIDER_RESET_VAL;
            insel <= `CONV_CLOCK_DIVIDER_RESET_VAL;
            pincfg <= `CONV_CLOCK_DIVIDER_RESET_VAL;
            scanmask <= `CONV_CLOCK_DIVIDER_RESET_VAL;
        end else begin
            if (wr && paddr == `CONV_CLOCK_DIVIDER_CTRL1_ADDR) begin
                ctrl1 <= pwdata[15:0] & `CONV_CLOCK_DIVIDER_C1_WMASK;
            end else if (wr && paddr == `CONV_CLOCK_DIVIDER_CTRL2_ADDR) begin
                ctrl2 <= pwdata[15:0] & `CONV_CLOCK_DIVIDER_C2_WMASK;
            end else if (wr && paddr == `CONV_CLOCK_DIVIDER_CTRL3_ADDR) begin
                ctrl3 <= pwdata[15:0] & `CONV_CLOCK_DIVIDER_C3_WMASK;
            end else if (wr && paddr == `CONV_CLOCK_DIVIDER_INSEL_ADDR) begin
                insel <= pwdata[15:0] & `CONV_CLOCK_DIVIDER_INSEL_WMASK;
            end else if (wr && paddr == `CONV_CLOCK_DIVIDER_PINCFG_ADDR) begin
                pincfg <= pwdata[15:0];
            end else if (wr && paddr == `CONV_CLOCK_DIVIDER_SCAN_ADDR) begin
                scanmask <= pwdata[15:0];
            end
            // Hardware updates after software so set wins
            if (sample_bit_clr) begin
                ctrl1[`CONV_CLOCK_DIVIDER_C1_SAMPLE_BIT] <= 1'b0;
            end
            if (sample_bit_set) begin
                ctrl1[`CONV_CLOCK_DIVIDER_C1_SAMPLE_BIT] <= 1'b1;
            end
            if (done_set) begin
                ctrl1[`CONV_CLOCK_DIVIDER_C1_DONE] <= 1'b1;
            end
        end
    end

    // Read data registered in setup phase, held into access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_sel) begin
            if (paddr == `CONV_CLOCK_DIVIDER_CTRL1_ADDR) begin
                prdata <= {16'h0000, ctrl1};
            end else if (paddr == `CONV_CLOCK_DIVIDER_CTRL2_ADDR) begin
                prdata <= {16'h0000, ctrl2[15:8], half, ctrl2[6:0]};
            end else if (paddr == `CONV_CLOCK_DIVIDER_CTRL3_ADDR) begin
                prdata <= {16'h0000, ctrl3};
            end else if (paddr == `CONV_CLOCK_DIVIDER_INSEL_ADDR) begin
                prdata <= {16'h0000, insel};
            end else if (paddr == `CONV_CLOCK_DIVIDER_PINCFG_ADDR) begin
                prdata <= {16'h0000, pincfg};
            end else if (paddr == `CONV_CLOCK_DIVIDER_SCAN_ADDR) begin
                prdata <= {16'h0000, scanmask};
            end else if (paddr == `CONV_CLOCK_DIVIDER_STAT_ADDR) begin
                // Sample/convert state in 17:16, last result in 9:0
                prdata <= {14'h0000, state[2:1], 6'h00, last_result};
            end else begin
                prdata <= 32'h0000_0000; // Unmapped reads zero
            end
        end
    end

    // Conversion clock tick: divider from pclk or fixed RC divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'h00;
            tad_tick <= 1'b0;
        end else if (div_cnt >= div_limit) begin
            // Period is the limit plus one clocks
            div_cnt <= 8'h00;
            tad_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            tad_tick <= 1'b0;
        end
    end

    // Static mux, reference and pin decode
    always @* begin
        case (ctrl2[`CONV_CLOCK_DIVIDER_C2_REF_HI:`CONV_CLOCK_DIVIDER_C2_REF_LO])
            3'h1: ref_select = 4'b0110;
            3'h2: ref_select = 4'b1001;
            3'h3: ref_select = 4'b0101;
            default: ref_select = 4'b1010; // 000 and 1xx
        endcase
        if (use_b && ctrl2[`CONV_CLOCK_DIVIDER_C2_ALTERNATE_MUX_MODE]) begin
            pos_channel = code_ok(insel[12:8]) ? insel[12:8] : 5'h00;
            neg_is_ch1 = insel[15];
        end else begin
            if (ctrl2[`CONV_CLOCK_DIVIDER_C2_SCAN]) begin
                // Index equals select code; 13 to 15 are internal channels
                pos_channel = {1'b0, scan_idx};
            end else begin
                pos_channel = code_ok(insel[4:0]) ? insel[4:0] : 5'h00;
            end
            neg_is_ch1 = insel[7];
        end
        channel_enable = {~pincfg[15:13], ~pincfg[12:0]};
        pin_digital_mode = pincfg[12:0];
    end

    // Sample/convert sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            tad_cnt <= 5'h00;
            seq_cnt <= 4'h0;
            use_b <= 1'b0;
            scan_idx <= 4'h0;
            half <= 1'b0;
            fill_ptr <= 3'h0;
            sample_hold <= 1'b0;
            convert_start <= 1'b0;
            result_addr <= 4'h0;
            result_write <= 1'b0;
            conv_irq <= 1'b0;
            sample_bit_clr <= 1'b0;
            sample_bit_set <= 1'b0;
            done_set <= 1'b0;
            last_result <= 10'h000;
        end else begin
            convert_start <= 1'b0;
            result_write <= 1'b0;
            conv_irq <= 1'b0;
            sample_bit_clr <= 1'b0;
            sample_bit_set <= 1'b0;
            done_set <= 1'b0;
            case (state)
                ST_IDLE: begin
                    sample_hold <= 1'b0;
                    if (!on) begin
                        seq_cnt <= 4'h0;
                        use_b <= 1'b0;
                        half <= 1'b0;
                        fill_ptr <= 3'h0;
                        scan_idx <= next_scan(scanmask, 4'h0, 1'b1);
                    end else if (ctrl1[`CONV_CLOCK_DIVIDER_C1_SAMPLE_BIT]) begin
                        state <= ST_SAMPLE_BIT;
                        tad_cnt <= 5'h00;
                        sample_hold <= 1'b1;
                    end
                end
                ST_SAMPLE_BIT: begin
                    if (!on) begin
                        state <= ST_IDLE;
                    end else if (trig == `CONV_CLOCK_DIVIDER_TRIG_AUTO) begin
                        // Internal counter ends sampling
                        if (tad_cnt >= auto_sample_time) begin
                            state <= ST_CONV;
                            tad_cnt <= 5'h00;
                            sample_hold <= 1'b0;
                            convert_start <= 1'b1;
                            sample_bit_clr <= 1'b1;
                        end else if (tad_tick) begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end else if (!ctrl1[`CONV_CLOCK_DIVIDER_C1_SAMPLE_BIT] && !sample_bit_set) begin
                        // Software clear ends sampling; auto-set lands a cycle late
                        state <= ST_CONV;
                        tad_cnt <= 5'h00;
                        sample_hold <= 1'b0;
                        convert_start <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (!on) begin
                        state <= ST_IDLE;
                    end else if (tad_tick && tad_cnt == CONV_TAD[4:0] - 5'h01) begin
                        // Store result in active half or whole buffer
                        result_write <= 1'b1;
                        last_result <= core_result;
                        done_set <= 1'b1;
                        if (ctrl2[`CONV_CLOCK_DIVIDER_C2_BUFFER_SPLIT_MODE]) begin
                            result_addr <= {half, fill_ptr};
                            fill_ptr <= fill_ptr + 3'h1;
                        end else begin
                            result_addr <= {fill_ptr == 3'h7 ? ~half : half, fill_ptr};
                            fill_ptr <= fill_ptr + 3'h1;
                            if (fill_ptr == 3'h7) begin
                                half <= ~half;
                            end
                        end
                        use_b <= ctrl2[`CONV_CLOCK_DIVIDER_C2_ALTERNATE_MUX_MODE] ? ~use_b : 1'b0;
                        if (seq_cnt == spi) begin
                            conv_irq <= 1'b1;
                            seq_cnt <= 4'h0;
                            scan_idx <= next_scan(scanmask, 4'h0, 1'b1);
                            use_b <= 1'b0;
                            fill_ptr <= 3'h0;
                            if (ctrl2[`CONV_CLOCK_DIVIDER_C2_BUFFER_SPLIT_MODE]) begin
                                half <= ~half;
                            end else begin
                                half <= 1'b0;
                            end
                        end else begin
                            seq_cnt <= seq_cnt + 4'h1;
                            if (!use_b || !ctrl2[`CONV_CLOCK_DIVIDER_C2_ALTERNATE_MUX_MODE]) begin
                                scan_idx <= next_scan(scanmask, scan_idx, 1'b0);
                            end
                        end
                        if (ctrl1[`CONV_CLOCK_DIVIDER_C1_AUTO]) begin
                            state <= ST_SAMPLE_BIT;
                            tad_cnt <= 5'h00;
                            sample_hold <= 1'b1;
                            sample_bit_set <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (tad_tick) begin
                        tad_cnt <= tad_cnt + 5'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [tb/conv_clock_divider_ctrl_sva.sv]
// Assertion checker for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
`include "conv_clock_divider_map.vh"
module conv_clock_divider_ctrl_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Converter side
    input wire logic [3:0] ref_select,
    input wire logic [4:0] pos_channel,
    input wire logic neg_is_ch1,
    input wire logic [15:0] channel_enable,
    input wire logic convert_start,
    input wire logic result_write,
    input wire logic conv_irq,
    input wire logic [12:0] pin_digital_mode
);
    // Shadows of written registers
    logic [15:0] c2, ins, pc;
    // Updated at the access edge, same as the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2 <= 16'h0000;
            ins <= 16'h0000;
            pc <= 16'h0000;
        end else if (psel && penable && pwrite) begin
            if (paddr == `CONV_CLOCK_DIVIDER_CTRL2_ADDR) c2 <= pwdata[15:0];
            if (paddr == `CONV_CLOCK_DIVIDER_INSEL_ADDR) ins <= pwdata[15:0];
            if (paddr == `CONV_CLOCK_DIVIDER_PINCFG_ADDR) pc <= pwdata[15:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Conversion must finish in bounded time
    sequence s_done; ##[1:800] result_write; endsequence
    property p_apb; pready && !pslverr; endproperty
    a_apb: assert property (p_apb) else $error("apb answer bad");
    property p_ref; ref_select == (c2[15] ? 4'hA : {!c2[13], c2[13], !c2[14], c2[14]}); endproperty
    a_ref: assert property (p_ref) else $error("reference pair wrong");
    property p_pin; pin_digital_mode == pc[12:0]; endproperty
    a_pin: assert property (p_pin) else $error("pin mode wrong");
    property p_chen; channel_enable == ~pc; endproperty
    a_chen: assert property (p_chen) else $error("channel enable wrong");
    property p_neg; !c2[0] |-> neg_is_ch1 == ins[7]; endproperty
    a_neg: assert property (p_neg) else $error("negative input wrong");
    property p_pos; !c2[0] && !c2[10] && !ins[4] |-> pos_channel == ins[4:0]; endproperty
    a_pos: assert property (p_pos) else $error("positive input wrong");
    property p_done; convert_start |-> s_done; endproperty
    a_done: assert property (p_done) else $error("no result after start");
    property p_irq; conv_irq |=> !conv_irq; endproperty
    a_irq: assert property (p_irq) else $error("interrupt pulse too long");
endmodule
bind conv_clock_divider_ctrl conv_clock_divider_ctrl_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .ref_select(ref_select), .pos_channel(pos_channel),
    .neg_is_ch1(neg_is_ch1), .channel_enable(channel_enable),
    .convert_start(convert_start), .result_write(result_write),
    .conv_irq(conv_irq), .pin_digital_mode(pin_digital_mode)
);
`default_nettype wire

// [tb/conv_clock_divider_core_model.sv]
// Behavioural converter core answering each conversion
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Conversion handshake
    input wire logic convert_start,
    input wire logic result_write,
    input wire logic [4:0] pos_channel,
    // Result to controller
    output logic [9:0] core_result
);
    logic busy; // Conversion in flight
    // Result tags the channel; toggles when idle so a late sample shows
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            core_result <= 10'h000;
        end else if (convert_start) begin
            busy <= 1'b1;
            core_result <= {5'h15, pos_channel};
        end else if (result_write) begin
            busy <= 1'b0;
        end else if (!busy) begin
            core_result <= ~core_result;
        end
    end
endmodule
`default_nettype wire

// [tb/test_adc_sequence_config_control.sv]
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
`include "conv_clock_divider_map.vh"
module test_adc_sequence_config_control;
    // Short counts keep the run brief
    localparam int CT = 4;
    localparam int RD = 3;
    localparam logic [11:0] A1 = `CONV_CLOCK_DIVIDER_CTRL1_ADDR, A2 = `CONV_CLOCK_DIVIDER_CTRL2_ADDR;
    localparam logic [11:0] A3 = `CONV_CLOCK_DIVIDER_CTRL3_ADDR, AI = `CONV_CLOCK_DIVIDER_INSEL_ADDR;
    localparam logic [11:0] AP = `CONV_CLOCK_DIVIDER_PINCFG_ADDR, AS = `CONV_CLOCK_DIVIDER_SCAN_ADDR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic neg_is_ch1, sample_hold, convert_start, result_write, conv_irq, sh_d;
    logic [3:0] ref_select, result_addr;
    logic [4:0] pos_channel;
    logic [15:0] channel_enable;
    logic [12:0] pin_digital_mode;
    logic [9:0] core_result;
    int n_fail = 0;
    int tests_run = 0;
    int cyc, t_cs, t_sr, conv_len, sample_bit_len, n_irq, base;
    int sl[4], cl[4];
    logic [15:0] cfg[4] = '{16'h0200, 16'h0600, 16'h0202, 16'h8200};
    logic [4:0] pq[$];
    logic nq[$];
    logic [3:0] aq[$];
    conv_clock_divider_ctrl #(.CONV_TAD(CT), .RC_DIV(RD)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_select(ref_select),
        .pos_channel(pos_channel), .neg_is_ch1(neg_is_ch1),
        .channel_enable(channel_enable), .sample_hold(sample_hold),
        .convert_start(convert_start), .result_addr(result_addr),
        .result_write(result_write), .conv_irq(conv_irq),
        .core_result(core_result), .pin_digital_mode(pin_digital_mode));
    conv_clock_divider_core_model i_core (.pclk(pclk), .presetn(presetn),
        .convert_start(convert_start), .result_write(result_write),
        .pos_channel(pos_channel), .core_result(core_result));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Log channel per start, address per result, and phase lengths
    always @(posedge pclk) begin
        cyc++;
        if (convert_start === 1'b1) begin
            pq.push_back(pos_channel);
            nq.push_back(neg_is_ch1);
            t_cs = cyc;
        end
        if (result_write === 1'b1) begin
            aq.push_back(result_addr);
            conv_len = cyc - t_cs;
        end
        if (conv_irq === 1'b1) n_irq++;
        if (sample_hold === 1'b1 && sh_d !== 1'b1) t_sr = cyc;
        if (sample_hold === 1'b0 && sh_d === 1'b1) sample_bit_len = cyc - t_sr;
        sh_d = sample_hold;
    end
    // One APB transfer; waits for pready, read data kept in rd_v
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Outputs launched by the write settle before any compare
        @(negedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 16'h0000);
        chk(rd_v, exp);
    endtask
    // Start sequences, wait for n results, then drop auto-start and drain
    task automatic run(input logic [15:0] c1, input int n);
        pq.delete();
        nq.delete();
        aq.delete();
        base = n_irq;
        xfer(1'b1, A1, c1);
        for (int k = 0; k < 2000 && aq.size() < n; k++) @(posedge pclk);
        xfer(1'b1, A1, 16'h80E0);
        repeat (200) @(posedge pclk);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Whole run needs under 2000 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        summarize();
    end
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk(ref_select, 32'hA);
        chk(channel_enable, 32'hFFFF);
        rdchk(A3, 32'h0);
        $display("reset test done");
        // Every reference code; fill status is read-only
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, A2, {c[2:0], 13'h0080});
            chk(ref_select, c[2] ? 4'hA : {!c[0], c[0], !c[1], c[1]});
            rdchk(A2, {c[2:0], 13'h0000});
        end
        xfer(1'b1, 12'h01C, 16'hFFFF);
        rdchk(12'h01C, 32'h0);
        xfer(1'b1, AP, 16'h31C1);
        chk(pin_digital_mode, 32'h11C1);
        chk(channel_enable, 32'hCE3E);
        // Internal channels and an unimplemented code
        for (int c = 13; c < 17; c++) begin
            xfer(1'b1, AI, {8'h00, c[0], 2'b00, c[4:0]});
            chk(pos_channel, c < 16 ? c : 0);
            chk(neg_is_ch1, c[0]);
        end
        $display("decode tests done");
        // Alternating muxes, split buffer, two per interrupt
        xfer(1'b1, A3, 16'h0200);
        xfer(1'b1, AI, 16'h8503);
        xfer(1'b1, A2, 16'h0007);
        run(16'h80E6, 4);
        for (int i = 0; i < 4; i++) begin
            chk(pq[i], i[0] ? 5 : 3);
            chk(nq[i], i[0]);
            chk(aq[i], {i[1], 2'b00, i[0]});
        end
        chk(n_irq - base, aq.size() / 2);
        // Scan restarts after each interrupt, unified buffer
        // Off first, so no sequence count or mux state carries over
        xfer(1'b1, A1, 16'h0000);
        xfer(1'b1, AP, 16'h11C0);
        xfer(1'b1, AS, 16'h2012);
        xfer(1'b1, A2, 16'h0404);
        run(16'h80E6, 4);
        for (int i = 0; i < 4; i++) begin
            chk(pq[i], i[0] ? 4 : 1);
            chk(aq[i], i[0]);
        end
        chk(n_irq - base, aq.size() / 2);
        rdchk(`CONV_CLOCK_DIVIDER_STAT_ADDR, {22'h0, 5'h15, pq[pq.size() - 1]});
        $display("sequence tests done");
        // Reset mid-run, then single shots: timing and half swapping
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b1, A2, 16'h0002);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, A3, cfg[k]);
            run(16'h80E2, 1);
            sl[k] = sample_bit_len;
            cl[k] = conv_len;
            chk(aq.size(), 1);
            chk(aq[0], {k[0], 3'b000});
            chk(n_irq - base, 1);
            rdchk(A2, {24'h0, !k[0], 7'h02});
        end
        chk(sl[1] - sl[0], 4);
        chk(cl[2] - cl[0] >= 2 * CT - 2 && cl[2] - cl[0] <= 2 * CT + 2, 1);
        chk(cl[3] - cl[0] >= CT * (RD - 1) - 2 && cl[3] - cl[0] <= CT * (RD - 1) + 2, 1);
        $display("timing tests done");
        summarize();
    end
endmodule
`default_nettype wire
